// >>> rif_defines.svh
`ifndef RIF_DEFINES_SVH
`define RIF_DEFINES_SVH
// Contract
// - The lock flag at bit 4 is high while in synthesis, receive or transmit mode with the loop locked, else low.
// - The signal-level flag at bit 3 sets in receive when the level exceeds the threshold, clears on leaving receive or by a software write.
// - The read-only timeout flag at bit 2 sets when either receive timeout expires and clears on leaving receive or when the FIFO empties.
// - The read-only auto flag at bit 1 sets on entering the intermediate mode of an automatic sequence and clears on leaving it.
// - The sync flag at bit 0 sets once sync and, if filtering is on, address are seen, and clears on leaving receive or when the FIFO empties.
// - The sync flag is read-only in packet mode and write-one-to-clear in continuous mode.
// - The first timeout fires start value times sixteen bit periods after entering receive without a level event; zero disables it.
// - The second timeout fires its value times sixteen bit periods after the level event without payload done; zero disables it.

// register indices; the byte address is four times the index
`define RIF_IDX_FLAGS   6'h27
`define RIF_IDX_THR     6'h29
`define RIF_IDX_TMO1    6'h2a
`define RIF_IDX_TMO2    6'h2b
// control and interrupt indices are local to this block
`define RIF_IDX_CTRL    6'h3d
`define RIF_IDX_IRQ_ST  6'h3e
`define RIF_IDX_IRQ_MSK 6'h3f

// register byte addresses
`define RIF_ADDR_FLAGS   {`RIF_IDX_FLAGS, 2'h0}
`define RIF_ADDR_THR     {`RIF_IDX_THR, 2'h0}
`define RIF_ADDR_TMO1    {`RIF_IDX_TMO1, 2'h0}
`define RIF_ADDR_TMO2    {`RIF_IDX_TMO2, 2'h0}
`define RIF_ADDR_CTRL    {`RIF_IDX_CTRL, 2'h0}
`define RIF_ADDR_IRQ_ST  {`RIF_IDX_IRQ_ST, 2'h0}
`define RIF_ADDR_IRQ_MSK {`RIF_IDX_IRQ_MSK, 2'h0}

// flag bit positions
`define RIF_BIT_LOCK  4
`define RIF_BIT_RSSI  3
`define RIF_BIT_TMO   2
`define RIF_BIT_AUTO  1
`define RIF_BIT_SYNC  0

// control bit positions
`define RIF_CTRL_CONT    0
`define RIF_CTRL_ADDR_EN 1

// reset values
`define RIF_THR_RST  8'he4
`define RIF_TMO_RST  8'h00
`define RIF_CTRL_RST 2'h0

// timeout unit is sixteen bit periods
`define RIF_TMO_SHIFT 4

`define RIF_RESP_OKAY   2'h0
`define RIF_RESP_SLVERR 2'h2
`endif

// >>> rif_pkg.sv
package rif_pkg;
    typedef enum logic [2:0] {
        RIF_SLEEP,
        RIF_STBY,
        RIF_FS,
        RIF_RX,
        RIF_TX
    } rif_mode_type;

    typedef struct packed {
        logic [4:0]  flags;
        logic [4:0]  irq_st;
        logic [4:0]  irq_mask;
        logic [7:0]  thr;
        logic [7:0]  tmo1;
        logic [7:0]  tmo2;
        logic [1:0]  ctrl;
        logic        rssi_seen;
        logic        payload_seen;
        logic        irq;
        logic        aw_have;
        logic [7:0]  aw_addr;
        logic        w_have;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } rif_state_type;
endpackage : rif_pkg

// >>> rif_tmo_if.sv
interface rif_tmo_if #(
    parameter int VAL_W = 8
);
    logic             run;
    logic             clr;
    logic             tick;
    logic [VAL_W-1:0] value;
    logic             fire;

    modport ctl (output run, output clr, output tick, output value, input fire);
    modport tmr (input run, input clr, input tick, input value, output fire);
endinterface : rif_tmo_if

// >>> rif_timeout.sv
`include "rif_defines.svh"
module rif_timeout
    import rif_pkg::*;
#(
    parameter int VAL_W = 8
) (
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    rif_tmo_if.tmr    t
);
    localparam int CW = VAL_W + `RIF_TMO_SHIFT;

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          done;
        logic          fire;
    } rif_tmo_state_type;

    rif_tmo_state_type tmo_ff;
    rif_tmo_state_type nxt_tmo;
    logic [CW-1:0]     limit;

    if (VAL_W < 1 || VAL_W > 16) begin : g_chk
        $error("rif_timeout: VAL_W must be 1..16");
    end

    // value times sixteen bit periods; zero value never arms
    assign limit = CW'(t.value) << `RIF_TMO_SHIFT;
    assign t.fire = tmo_ff.fire;

    // count bit ticks while running, fire once then hold
    always_comb begin
        nxt_tmo = tmo_ff;
        nxt_tmo.fire = 1'b0;
        if (t.clr) begin
            nxt_tmo.cnt = '0;
            nxt_tmo.done = 1'b0;
        end else if (t.run && t.tick && !tmo_ff.done && (t.value != '0)) begin
            nxt_tmo.cnt = CW'(tmo_ff.cnt + 1'b1);
            if (CW'(tmo_ff.cnt + 1'b1) == limit) begin
                nxt_tmo.done = 1'b1;
                nxt_tmo.fire = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            tmo_ff <= '0;
        end else begin
            tmo_ff <= nxt_tmo;
        end
    end
endmodule : rif_timeout

// >>> rif_flags.sv
`include "rif_defines.svh"
module rif_flags
    import rif_pkg::*;
(
    input  wire logic         sys_clk_i,
    input  wire logic         rst_i,
    // axi4-lite slave
    input  wire logic [7:0]   s_axi_awaddr_i,
    input  wire logic         s_axi_awvalid_i,
    output logic              s_axi_awready_o,
    input  wire logic [31:0]  s_axi_wdata_i,
    input  wire logic [3:0]   s_axi_wstrb_i,
    input  wire logic         s_axi_wvalid_i,
    output logic              s_axi_wready_o,
    output logic [1:0]        s_axi_bresp_o,
    output logic              s_axi_bvalid_o,
    input  wire logic         s_axi_bready_i,
    input  wire logic [7:0]   s_axi_araddr_i,
    input  wire logic         s_axi_arvalid_i,
    output logic              s_axi_arready_o,
    output logic [31:0]       s_axi_rdata_o,
    output logic [1:0]        s_axi_rresp_o,
    output logic              s_axi_rvalid_o,
    input  wire logic         s_axi_rready_i,
    // radio core status, same clock
    input  wire rif_mode_type mode_i,
    input  wire logic         synth_lock_i,
    input  wire logic [7:0]   measured_signal_level_i,
    input  wire logic         sync_detect_i,
    input  wire logic         addr_detect_i,
    input  wire logic         payload_done_flag_i,
    input  wire logic         fifo_empty_i,
    input  wire logic         bit_tick_i,
    input  wire logic         intermediate_mode_i,
    // results
    output logic [7:0]        irq_flags_first_o,
    output logic              irq_o
);
    rif_state_type cur_ff;
    rif_state_type nxt_st;
    logic          rx;
    logic          wr_go;
    logic [4:0]    flag_clr;
    logic [4:0]    st_clr;
    logic          rssi_hit;
    logic          sync_hit;
    logic [4:0]    ev;

    rif_tmo_if #(.VAL_W(8)) tmo_start ();
    rif_tmo_if #(.VAL_W(8)) tmo_level ();

    ////////////////////////////////////////////////////////////////////////////////
    // receive timeouts

    // first timer restarts on every rx entry, stops at the level event
    assign tmo_start.run   = rx && !cur_ff.rssi_seen;
    assign tmo_start.clr   = !rx;
    assign tmo_start.tick  = bit_tick_i;
    assign tmo_start.value = cur_ff.tmo1;
    // second timer runs from the level event until payload done
    assign tmo_level.run   = cur_ff.rssi_seen && !cur_ff.payload_seen;
    assign tmo_level.clr   = !rx;
    assign tmo_level.tick  = bit_tick_i;
    assign tmo_level.value = cur_ff.tmo2;

    rif_timeout #(.VAL_W(8)) u_tmo_start (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .t         (tmo_start.tmr)
    );

    rif_timeout #(.VAL_W(8)) u_tmo_level (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .t         (tmo_level.tmr)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // bus handshakes and outputs

    assign s_axi_awready_o   = !cur_ff.aw_have;
    assign s_axi_wready_o    = !cur_ff.w_have;
    assign s_axi_arready_o   = !cur_ff.rvalid;
    assign s_axi_bvalid_o    = cur_ff.bvalid;
    assign s_axi_bresp_o     = cur_ff.bresp;
    assign s_axi_rvalid_o    = cur_ff.rvalid;
    assign s_axi_rdata_o     = cur_ff.rdata;
    assign s_axi_rresp_o     = cur_ff.rresp;
    assign irq_flags_first_o = 8'(cur_ff.flags); // upper bits belong elsewhere, read zero
    assign irq_o             = cur_ff.irq;

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        nxt_st   = cur_ff;
        rx       = (mode_i == RIF_RX);
        // write only when both halves are held and no response is pending
        wr_go    = cur_ff.aw_have && cur_ff.w_have && !cur_ff.bvalid;
        flag_clr = '0;
        st_clr   = '0;

        // address and data channels, taken in either order
        if (s_axi_awvalid_i && !cur_ff.aw_have) begin
            nxt_st.aw_have = 1'b1;
            nxt_st.aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && !cur_ff.w_have) begin
            nxt_st.w_have = 1'b1;
            nxt_st.wdata  = s_axi_wdata_i;
            nxt_st.wstrb  = s_axi_wstrb_i;
        end
        if (cur_ff.bvalid && s_axi_bready_i) begin
            nxt_st.bvalid = 1'b0;
        end

        // register writes; all fields sit in byte lane zero
        if (wr_go) begin
            nxt_st.aw_have = 1'b0;
            nxt_st.w_have  = 1'b0;
            nxt_st.bvalid  = 1'b1;
            nxt_st.bresp   = `RIF_RESP_OKAY;
            unique case (cur_ff.aw_addr)
                `RIF_ADDR_FLAGS: begin
                    if (cur_ff.wstrb[0]) flag_clr = cur_ff.wdata[4:0];
                end
                `RIF_ADDR_THR: begin
                    if (cur_ff.wstrb[0]) nxt_st.thr = cur_ff.wdata[7:0];
                end
                `RIF_ADDR_TMO1: begin
                    if (cur_ff.wstrb[0]) nxt_st.tmo1 = cur_ff.wdata[7:0];
                end
                `RIF_ADDR_TMO2: begin
                    if (cur_ff.wstrb[0]) nxt_st.tmo2 = cur_ff.wdata[7:0];
                end
                `RIF_ADDR_CTRL: begin
                    if (cur_ff.wstrb[0]) nxt_st.ctrl = cur_ff.wdata[1:0];
                end
                `RIF_ADDR_IRQ_ST: begin
                    if (cur_ff.wstrb[0]) st_clr = cur_ff.wdata[4:0];
                end
                `RIF_ADDR_IRQ_MSK: begin
                    if (cur_ff.wstrb[0]) nxt_st.irq_mask = cur_ff.wdata[4:0];
                end
                default: begin
                    nxt_st.bresp = `RIF_RESP_SLVERR;
                end
            endcase
        end

        // reads answer one cycle after the address is taken
        if (s_axi_arvalid_i && !cur_ff.rvalid) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp  = `RIF_RESP_OKAY;
            nxt_st.rdata  = '0;
            unique case (s_axi_araddr_i)
                `RIF_ADDR_FLAGS:   nxt_st.rdata = 32'(cur_ff.flags);
                `RIF_ADDR_THR:     nxt_st.rdata = 32'(cur_ff.thr);
                `RIF_ADDR_TMO1:    nxt_st.rdata = 32'(cur_ff.tmo1);
                `RIF_ADDR_TMO2:    nxt_st.rdata = 32'(cur_ff.tmo2);
                `RIF_ADDR_CTRL:    nxt_st.rdata = 32'(cur_ff.ctrl);
                `RIF_ADDR_IRQ_ST:  nxt_st.rdata = 32'(cur_ff.irq_st);
                `RIF_ADDR_IRQ_MSK: nxt_st.rdata = 32'(cur_ff.irq_mask);
                default:           nxt_st.rresp = `RIF_RESP_SLVERR;
            endcase
        end else if (cur_ff.rvalid && s_axi_rready_i) begin
            nxt_st.rvalid = 1'b0;
        end

        // lock follows the synthesizer only in active modes
        nxt_st.flags[`RIF_BIT_LOCK] = synth_lock_i
            && (mode_i == RIF_FS || mode_i == RIF_RX || mode_i == RIF_TX);

        // level flag: hardware set beats a software clear in the same cycle
        rssi_hit = rx && (measured_signal_level_i > cur_ff.thr);
        nxt_st.flags[`RIF_BIT_RSSI] = rssi_hit
            || (cur_ff.flags[`RIF_BIT_RSSI] && rx && !flag_clr[`RIF_BIT_RSSI]);

        // timer gating kept apart from the flag so software clears do not rearm
        nxt_st.rssi_seen    = rx && (cur_ff.rssi_seen || rssi_hit);
        nxt_st.payload_seen = rx && (cur_ff.payload_seen || payload_done_flag_i);

        // timeout flag ignores software writes; a fire landing as rx ends is
        // dropped so the flag never reads set outside rx
        nxt_st.flags[`RIF_BIT_TMO] = rx && (tmo_start.fire || tmo_level.fire
            || (cur_ff.flags[`RIF_BIT_TMO] && !fifo_empty_i));

        // sleep-mode lag lives in the sequencer that drives this level
        nxt_st.flags[`RIF_BIT_AUTO] = intermediate_mode_i;

        // sync flag, clearable by software only in continuous mode
        sync_hit = rx && sync_detect_i
            && (!cur_ff.ctrl[`RIF_CTRL_ADDR_EN] || addr_detect_i);
        nxt_st.flags[`RIF_BIT_SYNC] = sync_hit
            || (cur_ff.flags[`RIF_BIT_SYNC] && rx && !fifo_empty_i
                && !(cur_ff.ctrl[`RIF_CTRL_CONT] && flag_clr[`RIF_BIT_SYNC]));

        // rising flags latch into sticky status, set wins over clear
        ev            = nxt_st.flags & ~cur_ff.flags;
        nxt_st.irq_st = ev | (cur_ff.irq_st & ~st_clr);
        nxt_st.irq    = |(nxt_st.irq_st & nxt_st.irq_mask);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            cur_ff      <= '0;
            cur_ff.thr  <= `RIF_THR_RST;
            cur_ff.tmo1 <= `RIF_TMO_RST;
            cur_ff.tmo2 <= `RIF_TMO_RST;
            cur_ff.ctrl <= `RIF_CTRL_RST;
        end else begin
            cur_ff <= nxt_st;
        end
    end
endmodule : rif_flags

// >>> rif_flags_props.sv
module rif_flags_props
    import rif_pkg::*;
(
    input wire logic         sys_clk_i,
    input wire logic         rst_i,
    input wire logic         s_axi_arvalid_i,
    input wire logic         s_axi_arready_o,
    input wire logic         s_axi_rvalid_o,
    input wire logic         s_axi_rready_i,
    input wire logic [31:0]  s_axi_rdata_o,
    input wire logic         s_axi_bvalid_o,
    input wire logic         s_axi_bready_i,
    input wire logic [1:0]   s_axi_bresp_o,
    input wire rif_mode_type mode_i,
    input wire logic         synth_lock_i,
    input wire logic         sync_detect_i,
    input wire logic         addr_detect_i,
    input wire logic         intermediate_mode_i,
    input wire logic [7:0]   irq_flags_first_o,
    input wire logic         irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////
    // each flag follows its cause one edge later
    property p_lock_on;
        synth_lock_i && (mode_i inside {RIF_FS, RIF_RX, RIF_TX}) |=> irq_flags_first_o[4];
    endproperty
    a_lock_on: assert property (p_lock_on) else $error("lock flag missing");
    property p_lock_off;
        !synth_lock_i || (mode_i inside {RIF_SLEEP, RIF_STBY}) |=> !irq_flags_first_o[4];
    endproperty
    a_lock_off: assert property (p_lock_off) else $error("lock flag stuck");
    property p_rx_off;
        mode_i != RIF_RX |=> irq_flags_first_o[3:2] == 2'h0;
    endproperty
    a_rx_off: assert property (p_rx_off) else $error("rx flags kept outside rx");
    property p_auto;
        1'b1 |=> irq_flags_first_o[1] == $past(intermediate_mode_i);
    endproperty
    a_auto: assert property (p_auto) else $error("auto flag wrong");
    property p_sync_set;
        mode_i == RIF_RX && sync_detect_i && addr_detect_i |=> irq_flags_first_o[0];
    endproperty
    a_sync_set: assert property (p_sync_set) else $error("sync flag missing");
    property p_sync_off;
        mode_i != RIF_RX && !sync_detect_i |=> !irq_flags_first_o[0];
    endproperty
    a_sync_off: assert property (p_sync_off) else $error("sync flag kept outside rx");
    ////////////////////////////////////////
    // bus answers stand until taken
    property p_rd;
        s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
    endproperty
    a_rd: assert property (p_rd) else $error("read answer late");
    property p_rhold;
        s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data dropped");
    property p_bhold;
        s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    c_tmo: cover property (irq_flags_first_o[2]);
    c_sync: cover property (irq_flags_first_o[0]);
    c_irq: cover property (irq_o);
endmodule : rif_flags_props

// >>> rif_flags_tb.sv
`include "rif_defines.svh"
module rif_flags_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rif_pkg::*;
    logic         clk = 1'b0, rst = 1'b1;
    logic [7:0]   awaddr = 8'h00, araddr = 8'h00;
    logic [3:0]   strb = 4'hf;
    logic         pd = 1'b0, slow = 1'b0;
    logic         awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
    logic [31:0]  wdata = 32'h0;
    rif_mode_type mode = RIF_SLEEP;
    logic         lock = 1'b0, sync = 1'b0, adr = 1'b0, fe = 1'b0, tk = 1'b0, im = 1'b0;
    logic [7:0]   lvl = 8'h00;
    logic         awrdy, wrdy, bvalid, arrdy, rvalid, irq;
    logic [1:0]   bresp, rresp;
    logic [31:0]  rdata;
    logic [7:0]   flags;
    int           n_mismatch = 0, samples_checked = 0;
    // 40 MHz clock
    always #12.5 clk = ~clk;
    rif_flags dut_u (.sys_clk_i(clk), .rst_i(rst), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awv), .s_axi_awready_o(awrdy), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(strb), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv), .s_axi_arready_o(arrdy),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .mode_i(mode), .synth_lock_i(lock),
        .measured_signal_level_i(lvl), .sync_detect_i(sync), .addr_detect_i(adr),
        .payload_done_flag_i(pd), .fifo_empty_i(fe), .bit_tick_i(tk),
        .intermediate_mode_i(im), .irq_flags_first_o(flags), .irq_o(irq));
    ////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // handshakes are judged at the falling edge, where everything has settled
    // ready stays up between transfers; with slow set it waits one cycle
    // after the answer shows, so a held answer gets exercised
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, tb, sb;
        tb = 1'b0;
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= !slow;
        while (!tb) begin
            @(negedge clk);
            ta = awv & awrdy;
            tw = wv & wrdy;
            tb = bvalid & bready;
            sb = bvalid;
            if (tb) chk("bresp", {30'h0, bresp}, {30'h0, er});
            @(posedge clk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
            if (sb && !tb) bready <= 1'b1;
        end
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ta, tr, sr;
        tr = 1'b0;
        araddr <= a;
        arv <= 1'b1;
        rready <= !slow;
        while (!tr) begin
            @(negedge clk);
            ta = arv & arrdy;
            tr = rvalid & rready;
            sr = rvalid;
            if (tr) chk("rdata", rdata, ed);
            if (tr) chk("rresp", {30'h0, rresp}, {30'h0, er});
            @(posedge clk);
            if (ta) arv <= 1'b0;
            if (sr && !tr) rready <= 1'b1;
        end
    endtask : rd
    // flags land one edge after their cause
    task automatic cf(input logic [7:0] ef, input logic ei);
        @(posedge clk);
        @(negedge clk);
        chk("flags", {24'h0, flags}, {24'h0, ef});
        chk("irq", {31'h0, irq}, {31'h0, ei});
        @(posedge clk);
    endtask : cf
    task automatic tick(input int n);
        repeat (n) begin
            tk <= 1'b1;
            @(posedge clk);
            tk <= 1'b0;
            @(posedge clk);
        end
    endtask : tick
    task automatic sp(input logic a);
        sync <= 1'b1;
        adr <= a;
        @(posedge clk);
        sync <= 1'b0;
        adr <= 1'b0;
    endtask : sp
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////
    // whole run is a few hundred cycles; this margin cuts a hung handshake
    initial begin
        #(25 * 8000);
        n_mismatch++;
        wrap_up();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(`RIF_ADDR_THR, 32'he4, 2'h0);
        rd(`RIF_ADDR_TMO1, 32'h0, 2'h0);
        rd(`RIF_ADDR_CTRL, 32'h0, 2'h0);
        rd(8'h1c, 32'h0, 2'h2); // no register at this address
        wr(8'h1c, 32'hff, 2'h2);
        // late ready keeps the answers standing for a cycle
        slow = 1'b1;
        wr(`RIF_ADDR_THR, 32'h5a, 2'h0);
        rd(`RIF_ADDR_THR, 32'h5a, 2'h0);
        slow = 1'b0;
        // byte lane zero off: the write must leave the register alone
        strb <= 4'he;
        wr(`RIF_ADDR_THR, 32'h11, 2'h0);
        strb <= 4'hf;
        rd(`RIF_ADDR_THR, 32'h5a, 2'h0);
        $display("test registers done");
        lock <= 1'b1;
        for (int m = 0; m < 5; m++) begin
            mode <= rif_mode_type'(m[2:0]);
            cf((m >= 2) ? 8'h10 : 8'h00, 1'b0);
        end
        lock <= 1'b0;
        cf(8'h00, 1'b0);
        wr(`RIF_ADDR_IRQ_ST, 32'h1f, 2'h0);
        $display("test lock done");
        wr(`RIF_ADDR_THR, 32'h40, 2'h0);
        wr(`RIF_ADDR_IRQ_MSK, 32'h08, 2'h0);
        mode <= RIF_RX;
        lvl <= 8'h40;
        cf(8'h00, 1'b0);
        lvl <= 8'h41;
        cf(8'h08, 1'b1);
        lvl <= 8'h00;
        wr(`RIF_ADDR_FLAGS, 32'h08, 2'h0);
        cf(8'h00, 1'b1);
        rd(`RIF_ADDR_IRQ_ST, 32'h08, 2'h0);
        wr(`RIF_ADDR_IRQ_ST, 32'h08, 2'h0);
        cf(8'h00, 1'b0);
        wr(`RIF_ADDR_IRQ_MSK, 32'h00, 2'h0);
        mode <= RIF_STBY;
        $display("test level done");
        wr(`RIF_ADDR_TMO1, 32'h01, 2'h0);
        mode <= RIF_RX;
        cf(8'h00, 1'b0);
        tick(15);
        cf(8'h00, 1'b0);
        tick(1);
        cf(8'h04, 1'b0);
        wr(`RIF_ADDR_FLAGS, 32'h04, 2'h0);
        cf(8'h04, 1'b0);
        fe <= 1'b1;
        cf(8'h00, 1'b0);
        fe <= 1'b0;
        mode <= RIF_STBY;
        wr(`RIF_ADDR_TMO1, 32'h00, 2'h0);
        wr(`RIF_ADDR_TMO2, 32'h01, 2'h0);
        mode <= RIF_RX;
        lvl <= 8'hff;
        cf(8'h08, 1'b0);
        tick(15);
        cf(8'h08, 1'b0);
        tick(1);
        cf(8'h0c, 1'b0);
        mode <= RIF_STBY;
        cf(8'h00, 1'b0);
        // payload done in time holds the second timer off
        mode <= RIF_RX;
        pd <= 1'b1;
        cf(8'h08, 1'b0);
        pd <= 1'b0;
        tick(16);
        cf(8'h08, 1'b0);
        mode <= RIF_SLEEP;
        cf(8'h00, 1'b0);
        $display("test timeout done");
        // sleep may lag the auto flag, so a spare cycle is allowed
        im <= 1'b1;
        @(posedge clk);
        cf(8'h02, 1'b0);
        wr(`RIF_ADDR_FLAGS, 32'h02, 2'h0);
        cf(8'h02, 1'b0);
        im <= 1'b0;
        @(posedge clk);
        cf(8'h00, 1'b0);
        $display("test auto done");
        mode <= RIF_RX;
        lvl <= 8'h00;
        sp(1'b0);
        cf(8'h01, 1'b0);
        wr(`RIF_ADDR_FLAGS, 32'h01, 2'h0);
        cf(8'h01, 1'b0);
        fe <= 1'b1;
        cf(8'h00, 1'b0);
        fe <= 1'b0;
        wr(`RIF_ADDR_CTRL, 32'h03, 2'h0);
        rd(`RIF_ADDR_CTRL, 32'h03, 2'h0);
        sp(1'b0);
        cf(8'h00, 1'b0);
        sp(1'b1);
        cf(8'h01, 1'b0);
        wr(`RIF_ADDR_FLAGS, 32'h01, 2'h0);
        cf(8'h00, 1'b0);
        sp(1'b1);
        mode <= RIF_STBY;
        cf(8'h00, 1'b0);
        $display("test sync done");
        wrap_up();
    end
endmodule : rif_flags_tb

bind rif_flags rif_flags_props chk_u (.sys_clk_i, .rst_i, .s_axi_arvalid_i, .s_axi_arready_o,
    .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_rdata_o, .s_axi_bvalid_o, .s_axi_bready_i,
    .s_axi_bresp_o, .mode_i, .synth_lock_i, .sync_detect_i, .addr_detect_i,
    .intermediate_mode_i, .irq_flags_first_o, .irq_o);
